/* hdl/line_event_pkg.sv */
// constants for the line event flag registers and the keypad tone detector control
// What this block does
// - second flags bits 0..3: tone a on, tone a idle, tone b on, tone b idle
// - second flags bit 4 bell on timer, bit 5 bell idle timer
// - second flags bit 6 keypad tone event, bit 7 caller-id fifo empty
// - a flag reads one while pending; all registers reset to zero
// - writing one clears a third-register flag; zero leaves it unchanged
// - third flags bit 0 die heat, bit 3 ground key, rest read zero
// - second mask has one enable per second flag, same position, one enables
// - third mask bit 0 enables die heat, bit 3 ground key, zero masks
// - control bit 7 turns detector on, bit 6 picks receive or transmit samples
// - tolerance bits 5:4 select 1.5, 2.5, 3.0 or 3.5 percent deviation
// - bits 3:0 give the estimation time constant directly, 0 to 15
// - larger time constant: slower tone decision, finer frequency estimate
// - writing one to flush bit 0 discards the last result; bits 7:1 reserved
// - read-only summary has one bit per flag register, zero when none pending
package line_event_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 6'h24;
  localparam logic [IDX_W-1:0] IDX_FLAGS_TWO = 6'h28;
  localparam logic [IDX_W-1:0] IDX_MASK_TWO = 6'h29;
  localparam logic [IDX_W-1:0] IDX_FLAGS_THREE = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_MASK_THREE = 6'h2b;
  localparam logic [IDX_W-1:0] IDX_DETECT_CTRL = 6'h30;
  localparam logic [IDX_W-1:0] IDX_FLUSH_CTRL = 6'h31;
  // second flag register bit positions
  localparam int BIT_TONE_A_ON = 0;
  localparam int BIT_TONE_A_IDLE = 1;
  localparam int BIT_TONE_B_ON = 2;
  localparam int BIT_TONE_B_IDLE = 3;
  localparam int BIT_BELL_ON = 4;
  localparam int BIT_BELL_IDLE = 5;
  localparam int BIT_KEYPAD_TONE = 6;
  localparam int BIT_CALLER_ID_FIFO = 7;
  // third flag register bit positions
  localparam int BIT_DIE_HEAT = 0;
  localparam int BIT_GROUND_KEY = 3;
  // summary vector bit positions
  localparam int BIT_SUM_TWO = 1;
  localparam int BIT_SUM_THREE = 2;
  // detector control fields
  localparam int BIT_DETECTOR_ON = 7;
  localparam int BIT_SOURCE_SELECT = 6;
  localparam int TOL_LSB = 4;
  localparam int TOL_W = 2;
  localparam int WIN_LSB = 0;
  localparam int WIN_W = 4;
  localparam int BIT_FLUSH = 0;
  // implemented bits per register
  localparam logic [REG_W-1:0] IMPL_TWO = 8'hff;
  localparam logic [REG_W-1:0] IMPL_THREE = 8'h09;
  // reset values
  localparam logic [REG_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [REG_W-1:0] RST_MASK = 8'h00;
  localparam logic [REG_W-1:0] RST_CTRL = 8'h00;
  // tolerance in tenths of a percent, four entries of six bits, code 0 lowest
  localparam int TOL_TENTHS_W = 6;
  localparam logic [23:0] TOL_TABLE = {6'h23, 6'h1e, 6'h19, 6'h0f};
endpackage

/* hdl/event_flag_bank.sv */
// sticky event flags cleared by writing one, with a matching enable mask
`timescale 1ns/10ps
module event_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // events, one-cycle pulses
  input wire logic [W-1:0] event_pulse,
  // software access
  input wire logic clear_strobe,
  input wire logic mask_strobe,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] flags_ff,
  output logic [W-1:0] mask_ff
);
  import line_event_pkg::*;

  logic [W-1:0] nxt_flags;
  logic [W-1:0] nxt_mask;
  logic [W-1:0] clr;

  always_comb begin
    clr = clear_strobe ? wdata : '0;
    // set wins over a clear in the same cycle; masking never blocks a set
    nxt_flags = ((flags_ff & ~clr) | event_pulse) & IMPL;
    nxt_mask = mask_strobe ? (wdata & IMPL) : mask_ff;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_ff <= '0;
      mask_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
    end
  end

  property p_set_wins;
    @(posedge core_clk) disable iff (reset)
      |(event_pulse & IMPL) |=> ((flags_ff & $past(event_pulse) & IMPL) == ($past(event_pulse) & IMPL));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event did not set its flag");

  property p_w1c;
    @(posedge core_clk) disable iff (reset)
      clear_strobe |=> ((flags_ff & $past(wdata) & ~$past(event_pulse)) == '0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write of one did not clear flag");

  property p_zero_keeps;
    @(posedge core_clk) disable iff (reset)
      1'b1 |=> ((flags_ff & ~$past(event_pulse) & ~($past(clear_strobe) ? $past(wdata) : '0))
                == ($past(flags_ff) & ~$past(event_pulse) & ~($past(clear_strobe) ? $past(wdata) : '0)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag changed without event or clear");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (reset)
      ((flags_ff | mask_ff) & ~IMPL) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  c_set_and_clear: cover property (@(posedge core_clk) disable iff (reset) clear_strobe && |(wdata & event_pulse));
endmodule

/* hdl/line_event_irq_and_tone_detect_ctrl.sv */
// line event flag registers, interrupt output and keypad tone detector control
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module line_event_irq_and_tone_detect_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [line_event_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [line_event_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [line_event_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // event pulses from the line logic
  input wire logic tone_a_on_event,
  input wire logic tone_a_idle_event,
  input wire logic tone_b_on_event,
  input wire logic tone_b_idle_event,
  input wire logic bell_on_event,
  input wire logic bell_idle_event,
  input wire logic keypad_tone_event,
  input wire logic caller_id_fifo_empty_event,
  input wire logic die_heat_event,
  input wire logic ground_key_event,
  // interrupt
  output logic irq,
  // keypad tone detector control
  output logic keypad_detector_on,
  output logic detector_source_select,
  output logic [line_event_pkg::TOL_W-1:0] tone_freq_tolerance,
  output logic [line_event_pkg::TOL_TENTHS_W-1:0] tone_tolerance_tenths,
  output logic [line_event_pkg::WIN_W-1:0] tone_estimate_window,
  output logic keypad_result_flush
);
  import line_event_pkg::*;

  logic waitrequest_ff;
  logic nxt_waitrequest;
  logic [DATA_W-1:0] readdata_ff;
  logic [DATA_W-1:0] nxt_readdata;
  logic irq_ff;
  logic nxt_irq;
  logic [REG_W-1:0] ctrl_ff;
  logic [REG_W-1:0] nxt_ctrl;
  logic [TOL_TENTHS_W-1:0] tol_tenths_ff;
  logic [TOL_TENTHS_W-1:0] nxt_tol_tenths;
  logic flush_ff;
  logic nxt_flush;

  logic accept;
  logic wr_ok;
  logic [IDX_W-1:0] index;
  logic sel_flags_two;
  logic sel_mask_two;
  logic sel_flags_three;
  logic sel_mask_three;
  logic sel_ctrl;
  logic sel_flush;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] events_two;
  logic [REG_W-1:0] events_three;
  logic [REG_W-1:0] flags_two;
  logic [REG_W-1:0] mask_two;
  logic [REG_W-1:0] flags_three;
  logic [REG_W-1:0] mask_three;
  logic [REG_W-1:0] summary;
  logic [REG_W-1:0] rd_byte;

  // bus decode: a request is taken at the edge where waitrequest is low
  always_comb begin
    accept = (read | write) & ~waitrequest_ff;
    index = address[ADDR_W-1:2];
    wr_ok = accept & write & byteenable[0] & (address[1:0] == 2'b00);
    wbyte = writedata[REG_W-1:0];
    sel_flags_two = wr_ok & (index == IDX_FLAGS_TWO);
    sel_mask_two = wr_ok & (index == IDX_MASK_TWO);
    sel_flags_three = wr_ok & (index == IDX_FLAGS_THREE);
    sel_mask_three = wr_ok & (index == IDX_MASK_THREE);
    sel_ctrl = wr_ok & (index == IDX_DETECT_CTRL);
    sel_flush = wr_ok & (index == IDX_FLUSH_CTRL);
  end

  // event routing into the two flag registers
  always_comb begin
    events_two = '0;
    events_two[BIT_TONE_A_ON] = tone_a_on_event;
    events_two[BIT_TONE_A_IDLE] = tone_a_idle_event;
    events_two[BIT_TONE_B_ON] = tone_b_on_event;
    events_two[BIT_TONE_B_IDLE] = tone_b_idle_event;
    events_two[BIT_BELL_ON] = bell_on_event;
    events_two[BIT_BELL_IDLE] = bell_idle_event;
    events_two[BIT_KEYPAD_TONE] = keypad_tone_event;
    events_two[BIT_CALLER_ID_FIFO] = caller_id_fifo_empty_event;
    events_three = '0;
    events_three[BIT_DIE_HEAT] = die_heat_event;
    events_three[BIT_GROUND_KEY] = ground_key_event;
  end

  event_flag_bank #(
    .W(REG_W),
    .IMPL(IMPL_TWO)
  ) u_bank_two (
    .core_clk(core_clk),
    .reset(reset),
    .event_pulse(events_two),
    .clear_strobe(sel_flags_two),
    .mask_strobe(sel_mask_two),
    .wdata(wbyte),
    .flags_ff(flags_two),
    .mask_ff(mask_two)
  );

  event_flag_bank #(
    .W(REG_W),
    .IMPL(IMPL_THREE)
  ) u_bank_three (
    .core_clk(core_clk),
    .reset(reset),
    .event_pulse(events_three),
    .clear_strobe(sel_flags_three),
    .mask_strobe(sel_mask_three),
    .wdata(wbyte),
    .flags_ff(flags_three),
    .mask_ff(mask_three)
  );

  // read mux; unmapped and misaligned addresses read zero
  always_comb begin
    summary = '0;
    summary[BIT_SUM_TWO] = |flags_two;
    summary[BIT_SUM_THREE] = |flags_three;
    rd_byte = '0;
    if (address[1:0] == 2'b00) begin
      case (index)
        IDX_SUMMARY: rd_byte = summary;
        IDX_FLAGS_TWO: rd_byte = flags_two;
        IDX_MASK_TWO: rd_byte = mask_two;
        IDX_FLAGS_THREE: rd_byte = flags_three;
        IDX_MASK_THREE: rd_byte = mask_three;
        IDX_DETECT_CTRL: rd_byte = ctrl_ff;
        default: rd_byte = '0;
      endcase
    end
  end

  // bus handshake: one wait cycle, then a single low cycle answers
  always_comb begin
    nxt_waitrequest = ~((read | write) & waitrequest_ff);
    nxt_readdata = readdata_ff;
    if (read & waitrequest_ff) begin
      nxt_readdata = {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= '0;
    end else begin
      waitrequest_ff <= nxt_waitrequest;
      readdata_ff <= nxt_readdata;
    end
  end

  // interrupt level from unmasked pending flags
  always_comb begin
    nxt_irq = |(flags_two & mask_two) | |(flags_three & mask_three);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // detector control and flush pulse
  always_comb begin
    nxt_ctrl = sel_ctrl ? wbyte : ctrl_ff;
    nxt_tol_tenths = TOL_TABLE[nxt_ctrl[TOL_LSB +: TOL_W]*TOL_TENTHS_W +: TOL_TENTHS_W];
    nxt_flush = sel_flush & wbyte[BIT_FLUSH];
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff <= RST_CTRL;
      tol_tenths_ff <= TOL_TABLE[TOL_TENTHS_W-1:0];
      flush_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      tol_tenths_ff <= nxt_tol_tenths;
      flush_ff <= nxt_flush;
    end
  end

  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;
  assign irq = irq_ff;
  assign keypad_detector_on = ctrl_ff[BIT_DETECTOR_ON];
  assign detector_source_select = ctrl_ff[BIT_SOURCE_SELECT];
  assign tone_freq_tolerance = ctrl_ff[TOL_LSB +: TOL_W];
  assign tone_tolerance_tenths = tol_tenths_ff;
  assign tone_estimate_window = ctrl_ff[WIN_LSB +: WIN_W];
  assign keypad_result_flush = flush_ff;

  property p_irq_level;
    @(posedge core_clk) disable iff (reset)
      ##1 (irq_ff == $past(|(flags_two & mask_two) | |(flags_three & mask_three)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow unmasked flags");

  property p_masked_sets;
    @(posedge core_clk) disable iff (reset)
      (keypad_tone_event && !mask_two[BIT_KEYPAD_TONE]) |=> flags_two[BIT_KEYPAD_TONE];
  endproperty
  a_masked_sets: assert property (p_masked_sets) else $error("masked event did not set flag");

  property p_ground_key_pos;
    @(posedge core_clk) disable iff (reset)
      ground_key_event |=> flags_three[BIT_GROUND_KEY] ##1 (summary[BIT_SUM_THREE] || $past(sel_flags_three));
  endproperty
  a_ground_key_pos: assert property (p_ground_key_pos) else $error("ground key flag missing");

  property p_bell_pos;
    @(posedge core_clk) disable iff (reset)
      bell_idle_event |=> flags_two[BIT_BELL_IDLE];
  endproperty
  a_bell_pos: assert property (p_bell_pos) else $error("bell idle flag not in bit five");

  property p_tone_a_pos;
    @(posedge core_clk) disable iff (reset)
      tone_a_idle_event |=> flags_two[BIT_TONE_A_IDLE];
  endproperty
  a_tone_a_pos: assert property (p_tone_a_pos) else $error("tone a idle flag not in bit one");

  property p_fifo_pos;
    @(posedge core_clk) disable iff (reset)
      caller_id_fifo_empty_event |=> flags_two[BIT_CALLER_ID_FIFO];
  endproperty
  a_fifo_pos: assert property (p_fifo_pos) else $error("fifo empty flag not in bit seven");

  property p_summary;
    @(posedge core_clk) disable iff (reset)
      (summary[BIT_SUM_TWO] == (flags_two != '0)) && (summary[0] == 1'b0);
  endproperty
  a_summary: assert property (p_summary) else $error("summary vector wrong");

  property p_answer;
    @(posedge core_clk) disable iff (reset)
      ((read || write) && waitrequest_ff) |=> !waitrequest_ff ##1 waitrequest_ff;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle after request");

  property p_ctrl_write;
    @(posedge core_clk) disable iff (reset)
      sel_ctrl |=> (keypad_detector_on == $past(writedata[BIT_DETECTOR_ON]))
                   && (tone_estimate_window == $past(writedata[WIN_LSB +: WIN_W]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("detector control not written");

  property p_tolerance;
    @(posedge core_clk) disable iff (reset)
      (tone_freq_tolerance == 2'b10) |-> (tone_tolerance_tenths == 6'h1e);
  endproperty
  a_tolerance: assert property (p_tolerance) else $error("tolerance code three point zero wrong");

  property p_flush_pulse;
    @(posedge core_clk) disable iff (reset)
      (sel_flush && writedata[BIT_FLUSH]) |=> keypad_result_flush ##1 !keypad_result_flush;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush is not a single pulse");

  property p_read_data;
    @(posedge core_clk) disable iff (reset)
      (read && waitrequest_ff && address == {IDX_FLAGS_TWO, 2'b00}) |=> (readdata_ff[REG_W-1:0] == $past(flags_two));
  endproperty
  a_read_data: assert property (p_read_data) else $error("flag read returned wrong byte");

  c_irq_rise: cover property (@(posedge core_clk) disable iff (reset) !irq_ff ##1 irq_ff);
  c_flush: cover property (@(posedge core_clk) disable iff (reset) keypad_result_flush);
  c_clear_three: cover property (@(posedge core_clk) disable iff (reset) sel_flags_three && |flags_three);
  c_read_summary: cover property (@(posedge core_clk) disable iff (reset)
    accept && read && index == IDX_SUMMARY && |summary);
endmodule

/* bench/line_event_irq_and_tone_detect_ctrl_bench.sv */
// self-checking bench for the line event flags, interrupt and keypad detector control
`timescale 1ns/10ps
module line_event_irq_and_tone_detect_ctrl_bench;
  import line_event_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [9:0] evts;
  logic irq;
  logic keypad_detector_on;
  logic detector_source_select;
  logic [TOL_W-1:0] tone_freq_tolerance;
  logic [TOL_TENTHS_W-1:0] tone_tolerance_tenths;
  logic [WIN_W-1:0] tone_estimate_window;
  logic keypad_result_flush;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'h3552_15b0;
  logic [5:0] tol_exp [4] = '{6'd15, 6'd25, 6'd30, 6'd35};
  int err_total = 0;
  int n_tests = 0;
  int flush_cnt = 0;
  int fc0;
  logic [7:0] acc;
  logic [7:0] v;

  line_event_irq_and_tone_detect_ctrl dut (
    .core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .tone_a_on_event(evts[0]), .tone_a_idle_event(evts[1]), .tone_b_on_event(evts[2]),
    .tone_b_idle_event(evts[3]), .bell_on_event(evts[4]), .bell_idle_event(evts[5]),
    .keypad_tone_event(evts[6]), .caller_id_fifo_empty_event(evts[7]), .die_heat_event(evts[8]),
    .ground_key_event(evts[9]), .irq(irq), .keypad_detector_on(keypad_detector_on),
    .detector_source_select(detector_source_select), .tone_freq_tolerance(tone_freq_tolerance),
    .tone_tolerance_tenths(tone_tolerance_tenths), .tone_estimate_window(tone_estimate_window),
    .keypad_result_flush(keypad_result_flush)
  );

  always #10 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] ad(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("BAD t=%0t no bus answer", $time);
      test_done();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, a, 32'h0000_0000, 4'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    evts <= 10'h001 << i;
    @(posedge core_clk);
    evts <= 10'h000;
  endtask

  task automatic wt;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // read results are compared against the oldest note when they appear
  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("BAD t=%0t unexpected read answer", $time);
      end else begin
        chk(readdata, exp_q.pop_front());
      end
    end
    if (keypad_result_flush === 1'b1) begin
      flush_cnt++;
    end
  end

  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'h1;
    evts = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, unmapped and misaligned places
    rd(ad(IDX_SUMMARY), 8'h00);
    rd(ad(IDX_FLAGS_TWO), 8'h00);
    rd(ad(IDX_MASK_TWO), 8'h00);
    rd(ad(IDX_FLAGS_THREE), 8'h00);
    rd(ad(IDX_MASK_THREE), 8'h00);
    rd(ad(IDX_DETECT_CTRL), 8'h00);
    rd(ad(IDX_FLUSH_CTRL), 8'h00);
    wr(8'ha5, 8'hff);
    rd(8'ha4, 8'h00);
    rd(8'ha5, 8'h00);
    wt();
    chk(irq, 0);
    chk(tone_tolerance_tenths, 15);
    // second flags set one by one while masked
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      acc[i] = 1'b1;
      rd(ad(IDX_FLAGS_TWO), acc);
    end
    wt();
    chk(irq, 0);
    rd(ad(IDX_SUMMARY), 8'h02);
    wr(ad(IDX_FLAGS_TWO), 8'h00);
    rd(ad(IDX_FLAGS_TWO), 8'hff);
    rnd = lfsr(rnd);
    wr(ad(IDX_FLAGS_TWO), rnd[7:0]);
    rd(ad(IDX_FLAGS_TWO), ~rnd[7:0]);
    wr(ad(IDX_FLAGS_TWO), 8'hff);
    rd(ad(IDX_FLAGS_TWO), 8'h00);
    // event in the very cycle the clear is taken: set wins
    fork
      wr(ad(IDX_FLAGS_TWO), 8'hff);
      begin
        @(posedge core_clk);
        pulse(5);
      end
    join
    rd(ad(IDX_FLAGS_TWO), 8'h20);
    wr(ad(IDX_FLAGS_TWO), 8'h20);
    rd(ad(IDX_FLAGS_TWO), 8'h00);
    rd(ad(IDX_SUMMARY), 8'h00);
    // one enable per position
    for (int i = 0; i < 8; i++) begin
      wr(ad(IDX_MASK_TWO), 8'h01 << i);
      pulse((i + 1) % 8);
      wt();
      chk(irq, 0);
      pulse(i);
      wt();
      chk(irq, 1);
      wr(ad(IDX_FLAGS_TWO), 8'hff);
      wt();
      chk(irq, 0);
    end
    rnd = lfsr(rnd);
    wr(ad(IDX_MASK_TWO), rnd[7:0]);
    rd(ad(IDX_MASK_TWO), rnd[7:0]);
    wr(ad(IDX_MASK_TWO), 8'h00);
    // third flags and enables
    pulse(8);
    pulse(9);
    rd(ad(IDX_FLAGS_THREE), 8'h09);
    rd(ad(IDX_SUMMARY), 8'h04);
    wt();
    chk(irq, 0);
    wr(ad(IDX_MASK_THREE), 8'hff);
    rd(ad(IDX_MASK_THREE), 8'h09);
    wt();
    chk(irq, 1);
    wr(ad(IDX_FLAGS_THREE), 8'hf6);
    rd(ad(IDX_FLAGS_THREE), 8'h09);
    wr(ad(IDX_FLAGS_THREE), 8'h01);
    rd(ad(IDX_FLAGS_THREE), 8'h08);
    wr(ad(IDX_MASK_THREE), 8'h01);
    wt();
    chk(irq, 0);
    wr(ad(IDX_FLAGS_THREE), 8'h08);
    rd(ad(IDX_FLAGS_THREE), 8'h00);
    wr(ad(IDX_MASK_THREE), 8'h00);
    // detector control, every window value and tolerance code
    for (int j = 0; j < 16; j++) begin
      rnd = lfsr(rnd);
      v = {rnd[7:6], j[1:0], j[3:0]};
      wr(ad(IDX_DETECT_CTRL), v);
      rd(ad(IDX_DETECT_CTRL), v);
      wt();
      chk(keypad_detector_on, v[7]);
      chk(detector_source_select, v[6]);
      chk(tone_freq_tolerance, j[1:0]);
      chk(tone_tolerance_tenths, tol_exp[j % 4]);
      chk(tone_estimate_window, j[3:0]);
    end
    bus(1'b1, ad(IDX_DETECT_CTRL), {24'h00_0000, ~v}, 4'h0);
    rd(ad(IDX_DETECT_CTRL), v);
    // result flush pulse
    fc0 = flush_cnt;
    wr(ad(IDX_FLUSH_CTRL), 8'hfe);
    wt();
    chk(flush_cnt - fc0, 0);
    wr(ad(IDX_FLUSH_CTRL), 8'h01);
    wt();
    chk(flush_cnt - fc0, 1);
    rd(ad(IDX_FLUSH_CTRL), 8'h00);
    wt();
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule
